// ---- sim/adc_status_reporting_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_status_reporting_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b1;
	logic sync_n = 1'b1;
	logic result_write = 1'b0;
	logic cal_write = 1'b0;
	logic idle_enter = 1'b0;
	logic cal_start = 1'b0;
	logic conv_start = 1'b0;
	logic [23:0] result_data = '0;
	logic [3:0] result_chan = '0;
	logic [15:0] error_bits = '0;
	wire sclk, cs_n, sdi, sdo, sdo_oe, ready_pin_n, fifo_err_summary;
	wire [7:0] status_flags;
	wire [23:0] data_word;
	integer seed = 32'hc7ecbe94;
	int fails = 0;
	int total_checks = 0;
	logic r = 1'b0;
	logic por = 1'b1;
	logic [3:0] ch = '0;
	logic [23:0] dat = '0;
	logic [23:0] rd;
	always #2.5 clk = ~clk;
	adc_status_reporting dut (.clk, .rst_n, .sclk, .cs_n, .sdi, .sdo, .sdo_oe, .sync_n,
		.result_write, .result_data, .result_chan, .cal_write, .idle_enter, .cal_start,
		.conv_start, .error_bits, .ready_pin_n, .fifo_err_summary, .status_flags, .data_word);
	host_link host (.sclk, .cs_n, .sdi, .sdo);
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		total_checks++;
		if (e !== g) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_stat();
		chk("status", {16'h0, r, |error_bits, 1'b0, por, ch}, {16'h0, status_flags});
		chk("ready_pin", {23'h0, r}, {23'h0, ready_pin_n});
		chk("err_copy", {23'h0, |error_bits}, {23'h0, fifo_err_summary});
		chk("data", dat, data_word);
		chk("sdo_oe", 24'h0, {23'h0, sdo_oe});
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask
	task automatic store(input logic [3:0] c);
		@(negedge clk);
		result_data = $random(seed);
		result_chan = c;
		pulse(result_write);
		r = 1'b1;
		chk_stat();
		repeat (3) @(negedge clk);
		chk_stat();
		@(negedge clk);
		{r, dat, ch} = {1'b0, result_data, c};
		chk_stat();
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#60000;
		fails++;
		stop_test();
	end
	initial begin
		// A real falling edge on reset, so no flop waits for a clock to leave the unknown state.
		#1 rst_n = 1'b0;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		chk_stat();
		repeat (4) @(negedge clk);
		host.xfer(2, 8'h40, 8, rd);
		chk("status_read", 24'h10, rd);
		repeat (8) @(negedge clk);
		por = 1'b0;
		chk_stat();
		host.xfer(0, 8'h00, 8, rd);
		host.xfer(0, 8'h7f, 8, rd);
		chk("unmapped", 24'h0, rd);
		repeat (8) @(negedge clk);
		chk_stat();
		for (int k = 0; k < 16; k++) begin
			store(k[3:0]);
			host.xfer(0, 8'h45, 8, rd);
			chk_stat();
			if (k[0]) begin
				host.xfer(0, 8'h42, 24, rd);
				chk("data_read", dat, rd);
				repeat (8) @(negedge clk);
				r = 1'b1;
				chk_stat();
			end
		end
		store(4'h3);
		fork
			host.xfer(0, 8'h42, 24, rd);
			begin
				#150;
				@(negedge clk);
				result_data = $random(seed);
				result_chan = 4'h5;
				pulse(result_write);
			end
		join
		chk("data_read", dat, rd);
		repeat (8) @(negedge clk);
		r = 1'b1;
		chk_stat();
		pulse(cal_write);
		r = 1'b0;
		chk_stat();
		pulse(conv_start);
		r = 1'b1;
		chk_stat();
		pulse(cal_write);
		pulse(idle_enter);
		chk_stat();
		pulse(cal_write);
		pulse(cal_start);
		chk_stat();
		store(4'h9);
		sync_n = 1'b0;
		repeat (4) @(negedge clk);
		r = 1'b1;
		chk_stat();
		sync_n = 1'b1;
		for (int k = 0; k < 6; k++) begin
			@(negedge clk);
			error_bits = k[0] ? 16'h0 : 16'(1 << ($unsigned($random(seed)) % 16));
			repeat (2) @(negedge clk);
			chk_stat();
		end
		@(negedge clk);
		rst_n = 1'b0;
		{r, por, ch, dat} = {1'b0, 1'b1, 4'h0, 24'h0};
		repeat (3) @(negedge clk);
		chk_stat();
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		chk_stat();
		host.xfer(0, 8'h40, 8, rd);
		chk("status_read", 24'h10, rd);
		stop_test();
	end
endmodule
`default_nettype wire

// ---- sim/host_link.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_link (
	output logic sclk, // Serial clock, still between frames.
	output logic cs_n, // Frame select, active low.
	output logic sdi, // Data to the device.
	input wire logic sdo // Data from the device.
);
	initial begin
		sclk = 1'b0;
		sdi = 1'b0;
		// Select is raised only after reset has fallen, so the link sees a clean reset edge.
		#2;
		cs_n = 1'b1;
	end
	task automatic xfer(input int lead, input logic [7:0] cmd, input int n,
		output logic [23:0] rd);
		logic [31:0] bits;
		bits = {cmd, 24'h0};
		rd = '0;
		cs_n = 1'b0;
		#7;
		repeat (lead) begin
			sdi = 1'b1;
			#6 sclk = 1'b1;
			#6 sclk = 1'b0;
		end
		for (int i = 0; i < 8 + n; i++) begin
			sdi = bits[31-i];
			if (i >= 8)
				rd = {rd[22:0], sdo};
			#6 sclk = 1'b1;
			#6 sclk = 1'b0;
		end
		#6 sdi = ~sdi;
		cs_n = 1'b1;
		#30;
	endtask
endmodule
`default_nettype wire

// ---- sim/status_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module status_monitor (
	input wire logic clk, // Master clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic result_write, // Result offered.
	input wire logic cal_write, // Coefficients stored.
	input wire logic [adc_status_pkg::ERR_W-1:0] error_bits, // Error levels.
	input wire logic ready_pin_n, // Ready pin.
	input wire logic fifo_err_summary, // Error copy.
	input wire logic [adc_status_pkg::BYTE_W-1:0] status_flags, // Status byte.
	input wire logic [adc_status_pkg::DATA_W-1:0] data_word // Data register.
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_pin; ready_pin_n == status_flags[7]; endproperty
	a_pin: assert property (p_pin) else $error("ready pin differs");
	property p_copy; fifo_err_summary == status_flags[6]; endproperty
	a_copy: assert property (p_copy) else $error("error copy differs");
	property p_err_set; |error_bits |=> status_flags[6]; endproperty
	a_err_set: assert property (p_err_set) else $error("error summary not set");
	property p_err_clr; error_bits == '0 |=> !status_flags[6]; endproperty
	a_err_clr: assert property (p_err_clr) else $error("error summary not clear");
	property p_rsvd; status_flags[5] == 1'b0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
	property p_warn; result_write && !cal_write ##1 !cal_write[*4] |-> status_flags[7]; endproperty
	a_warn: assert property (p_warn) else $error("ready low before store");
	property p_cal; cal_write |=> !status_flags[7]; endproperty
	a_cal: assert property (p_cal) else $error("ready high after store");
	property p_data; $changed(data_word) |-> $past(result_write, 5); endproperty
	a_data: assert property (p_data) else $error("data changed untimely");
	property p_chan; $changed(status_flags[3:0]) |-> $past(result_write, 5); endproperty
	a_chan: assert property (p_chan) else $error("channel changed untimely");
	property p_rst; disable iff (1'b0) !rst_n |-> status_flags == 8'h10; endproperty
	a_rst: assert property (p_rst) else $error("status reset value wrong");
	c_store: cover property (result_write ##5 $changed(data_word));
	c_cal: cover property (cal_write);
	c_err: cover property ($rose(fifo_err_summary));
endmodule
bind adc_status_reporting status_monitor mon (.clk, .rst_n, .result_write, .cal_write,
	.error_bits, .ready_pin_n, .fifo_err_summary, .status_flags, .data_word);
`default_nettype wire

// ---- src/adc_status_pkg.sv ----
// Overview of operation
// - Ready pin low exactly while ready bit low
// - Result or coefficient store clears ready bit
// - Finished data register read sets ready bit
// - Offset and gain reads leave ready alone
// - Idle, calibration or conversion start set ready
// - Sync low with unread data sets ready
// - Ready set four clocks before result write
// - Result arriving during data read is dropped
// - Error summary is OR of error bits
// - Error summary mirrored to FIFO status output
// - Error summary clears when no errors remain
// - Power-on flag set by reset, read clears
// - Channel field tracks result in data register
// - Channel field equals setup register index directly
// - Status read-only at 0x00, resets 0x10
// - Read/write bit one reads, zero writes
package adc_status_pkg;
	localparam int DATA_W = 24;
	localparam int ERR_W = 16;
	localparam int CHAN_W = 4;
	localparam int BYTE_W = 8;
	localparam int ADDR_W = 6;
	localparam int CNT_W = 5;
	localparam int PEND_W = 3;
	localparam int RW_POS = 6;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 6'h00;
	localparam logic [ADDR_W-1:0] ADDR_DATA = 6'h02;
	localparam logic [BYTE_W-1:0] STATUS_RESET = 8'h10;
	localparam logic [PEND_W-1:0] PRE_WRITE_CYCLES = 3'h4;
	localparam logic [PEND_W-1:0] PEND_LAST = 3'h1;
	localparam logic [CNT_W-1:0] BITS_BYTE = 5'h08;
	localparam logic [CNT_W-1:0] BITS_DATA = 5'h18;
	localparam int SYNC_W = 4;
	localparam int SY_CS = 0;
	localparam int SY_SYNC = 1;
	localparam int SY_DACT = 2;
	localparam int SY_SACT = 3;
	localparam logic [SYNC_W-1:0] SYNC_RESET = 4'h3;

	typedef struct packed {
		logic ready_n;
		logic err;
		logic rsvd;
		logic por;
		logic [CHAN_W-1:0] chan;
	} status_t;

	typedef struct packed {
		status_t status;
		logic [DATA_W-1:0] data;
	} snapshot_t;

	typedef struct packed {
		logic [SYNC_W-1:0] s1;
		logic [SYNC_W-1:0] s2;
	} sync_state_t;

	typedef enum logic [1:0] {
		LINK_BYTE_A,
		LINK_READ,
		LINK_WRITE
	} link_mode_t;

	typedef struct packed {
		link_mode_t mode;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] len;
		logic [DATA_W-1:0] shift;
		logic sdo;
		logic oe;
		logic data_act;
		logic stat_act;
	} link_state_t;

	typedef struct packed {
		status_t stat;
		logic [DATA_W-1:0] data;
		logic pend;
		logic [PEND_W-1:0] pend_cnt;
		logic [DATA_W-1:0] pend_data;
		logic [CHAN_W-1:0] pend_chan;
		logic unread;
		logic dact_prev;
		logic sact_prev;
		snapshot_t snap;
	} core_state_t;
endpackage

// ---- src/adc_status_reporting.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_status_reporting (
	input wire logic clk, // Converter master clock, 200 MHz.
	input wire logic rst_n, // Power-on reset, asynchronous, active low.
	input wire logic sclk, // Serial clock from the host.
	input wire logic cs_n, // Serial frame select, active low.
	input wire logic sdi, // Serial data from the host.
	output logic sdo, // Serial data to the host.
	output logic sdo_oe, // High while sdo is driven.
	input wire logic sync_n, // Synchronisation pin, active low.
	input wire logic result_write, // Pulse: conversion result offered.
	input wire logic [adc_status_pkg::DATA_W-1:0] result_data, // Offered result.
	input wire logic [adc_status_pkg::CHAN_W-1:0] result_chan, // Setup index of result.
	input wire logic cal_write, // Pulse: calibration coefficients stored.
	input wire logic idle_enter, // Pulse: converter enters idle or standby.
	input wire logic cal_start, // Pulse: calibration begins.
	input wire logic conv_start, // Pulse: conversion begins.
	input wire logic [adc_status_pkg::ERR_W-1:0] error_bits, // Error register levels.
	output logic ready_pin_n, // Data-ready pin, active low.
	output logic fifo_err_summary, // Error summary copy for FIFO status.
	output logic [adc_status_pkg::BYTE_W-1:0] status_flags, // Status register value.
	output logic [adc_status_pkg::DATA_W-1:0] data_word // Data register value.
);
	adc_status_pkg::core_state_t q;
	adc_status_pkg::core_state_t d;
	logic [adc_status_pkg::SYNC_W-1:0] async_in;
	logic [adc_status_pkg::SYNC_W-1:0] synced;
	logic link_data_act;
	logic link_stat_act;
	logic frame_rst_n;
	logic frame_idle;
	logic data_read_done;
	logic stat_read_done;
	logic store_now;

	assign frame_rst_n = rst_n & ~cs_n;
	assign async_in = {link_stat_act, link_data_act, sync_n, cs_n};

	bit_sync u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.din(async_in),
		.dout(synced)
	);

	serial_link u_link (
		.sclk(sclk),
		.frame_rst_n(frame_rst_n),
		.sdi(sdi),
		.snap(q.snap),
		.sdo(sdo),
		.sdo_oe(sdo_oe),
		.data_act(link_data_act),
		.stat_act(link_stat_act)
	);

	assign frame_idle = synced[adc_status_pkg::SY_CS];
	assign data_read_done = q.dact_prev & ~synced[adc_status_pkg::SY_DACT];
	assign stat_read_done = q.sact_prev & ~synced[adc_status_pkg::SY_SACT];
	assign store_now = q.pend && (q.pend_cnt == adc_status_pkg::PEND_LAST);

	always_comb begin
		d = q;
		d.dact_prev = synced[adc_status_pkg::SY_DACT];
		d.sact_prev = synced[adc_status_pkg::SY_SACT];
		d.stat.rsvd = 1'b0;
		d.stat.err = |error_bits;

		// Power-on sets the flag through reset only; a finished status read clears it.
		if (stat_read_done) begin
			d.stat.por = 1'b0;
		end

		if (data_read_done) begin
			d.stat.ready_n = 1'b1;
			d.unread = 1'b0;
		end

		if (idle_enter || cal_start || conv_start) begin
			d.stat.ready_n = 1'b1;
		end

		if (!synced[adc_status_pkg::SY_SYNC] && q.unread) begin
			d.stat.ready_n = 1'b1;
		end

		if (q.pend) begin
			d.pend_cnt = q.pend_cnt - 1'b1;
		end

		// The result is held back so that the ready bit warns before data changes.
		if (store_now) begin
			d.pend = 1'b0;
			d.pend_cnt = '0;
			if (synced[adc_status_pkg::SY_DACT]) begin
				d.stat.ready_n = 1'b1;
			end else begin
				d.data = q.pend_data;
				d.stat.chan = q.pend_chan;
				d.stat.ready_n = 1'b0;
				d.unread = 1'b1;
			end
		end

		if (result_write) begin
			d.pend = 1'b1;
			d.pend_cnt = adc_status_pkg::PRE_WRITE_CYCLES;
			d.pend_data = result_data;
			d.pend_chan = result_chan;
			d.stat.ready_n = 1'b1;
		end

		if (cal_write) begin
			d.stat.ready_n = 1'b0;
		end

		// The image seen by the link is frozen for the whole frame, so a read is atomic.
		if (frame_idle) begin
			d.snap.status = q.stat;
			d.snap.data = q.data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.stat <= adc_status_pkg::STATUS_RESET;
			q.snap.status <= adc_status_pkg::STATUS_RESET;
		end else begin
			q <= d;
		end
	end

	assign ready_pin_n = q.stat.ready_n;
	assign fifo_err_summary = q.stat.err;
	assign status_flags = q.stat;
	assign data_word = q.data;
endmodule
`default_nettype wire

// ---- src/bit_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module bit_sync (
	input wire logic clk, // Destination clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic [adc_status_pkg::SYNC_W-1:0] din, // Asynchronous levels.
	output logic [adc_status_pkg::SYNC_W-1:0] dout // Synchronised levels.
);
	adc_status_pkg::sync_state_t q;
	adc_status_pkg::sync_state_t d;

	always_comb begin
		d = q;
		d.s1 = din;
		d.s2 = q.s1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q.s1 <= adc_status_pkg::SYNC_RESET;
			q.s2 <= adc_status_pkg::SYNC_RESET;
		end else begin
			q <= d;
		end
	end

	assign dout = q.s2;
endmodule
`default_nettype wire

// ---- src/serial_link.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_link (
	input wire logic sclk, // Serial clock from the host.
	input wire logic frame_rst_n, // Low outside a frame or under reset.
	input wire logic sdi, // Serial data in, sampled on rising edge.
	input wire adc_status_pkg::snapshot_t snap, // Frozen register image.
	output logic sdo, // Serial data out.
	output logic sdo_oe, // High while driving sdo.
	output logic data_act, // Data register read under way.
	output logic stat_act // Status register read under way.
);
	adc_status_pkg::link_state_t q;
	adc_status_pkg::link_state_t d;
	logic [adc_status_pkg::BYTE_W-1:0] byte_in;

	always_comb begin
		d = q;
		byte_in = {q.shift[adc_status_pkg::BYTE_W-2:0], sdi};
		case (q.mode)
			adc_status_pkg::LINK_BYTE_A: begin
				// A leading one is not taken; the link waits at the first bit.
				if (!(q.cnt == '0 && sdi)) begin
					d.shift = {q.shift[adc_status_pkg::DATA_W-2:0], sdi};
					d.cnt = q.cnt + 1'b1;
					if (q.cnt == adc_status_pkg::BITS_BYTE - 1'b1) begin
						d.cnt = '0;
						if (byte_in[adc_status_pkg::RW_POS]) begin
							d.mode = adc_status_pkg::LINK_READ;
							d.oe = 1'b1;
							d.len = adc_status_pkg::BITS_BYTE;
							d.shift = '0;
							case (byte_in[adc_status_pkg::ADDR_W-1:0])
								adc_status_pkg::ADDR_STATUS: begin
									d.shift = {snap.status,
										{(adc_status_pkg::DATA_W-adc_status_pkg::BYTE_W){1'b0}}};
									d.stat_act = 1'b1;
								end
								adc_status_pkg::ADDR_DATA: begin
									d.shift = snap.data;
									d.len = adc_status_pkg::BITS_DATA;
									d.data_act = 1'b1;
								end
								// Other registers, offset and gain among them, raise no flag.
								default: begin
									d.shift = '0;
								end
							endcase
							d.sdo = d.shift[adc_status_pkg::DATA_W-1];
						end else begin
							// Writes are absorbed; the status register takes none.
							d.mode = adc_status_pkg::LINK_WRITE;
						end
					end
				end
			end
			adc_status_pkg::LINK_READ: begin
				d.shift = {q.shift[adc_status_pkg::DATA_W-2:0], 1'b0};
				d.sdo = d.shift[adc_status_pkg::DATA_W-1];
				d.cnt = q.cnt + 1'b1;
				if (q.cnt == q.len - 1'b1) begin
					d.mode = adc_status_pkg::LINK_BYTE_A;
					d.cnt = '0;
					d.oe = 1'b0;
					d.sdo = 1'b0;
					d.data_act = 1'b0;
					d.stat_act = 1'b0;
				end
			end
			adc_status_pkg::LINK_WRITE: begin
				d.cnt = q.cnt + 1'b1;
				if (q.cnt == adc_status_pkg::BITS_BYTE - 1'b1) begin
					d.mode = adc_status_pkg::LINK_BYTE_A;
					d.cnt = '0;
				end
			end
			default: begin
				d.mode = adc_status_pkg::LINK_BYTE_A;
				d.cnt = '0;
			end
		endcase
	end

	// The frame's own select ends every transfer, since sclk stops between frames.
	always_ff @(posedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sdo = q.sdo;
	assign sdo_oe = q.oe;
	assign data_act = q.data_act;
	assign stat_act = q.stat_act;
endmodule
`default_nettype wire
